// ### src/hold_timer.v
`timescale 1ns/1ps
`default_nettype none

`include "transponder_defines.vh"

// Measures how long a button is held, in ticks and whole seconds.
// Counts stay valid in the release cycle and are cleared on the next press.
module hold_timer (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       btn,
  input  wire       tick,
  output reg        held,
  output wire       press,
  output wire       release_evt,
  output reg  [7:0] ticks,
  output reg  [4:0] secs
);

  localparam [3:0] TENTHS_LAST = `TICKS_PER_S - 1;

  reg [3:0] tenth_reg;

  assign press       = btn & ~held;
  assign release_evt = held & ~btn;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      held      <= 1'b0;
      ticks     <= 8'h00;
      secs      <= 5'h00;
      tenth_reg <= 4'h0;
    end else begin
      held <= btn;
      if (press) begin
        ticks     <= 8'h00;
        secs      <= 5'h00;
        tenth_reg <= 4'h0;
      end else if (held && btn && tick) begin
        // Saturate so long holds never wrap back into a short window
        if (ticks != 8'hFF)
          ticks <= ticks + 8'h01;
        if (tenth_reg == TENTHS_LAST) begin
          tenth_reg <= 4'h0;
          if (secs != 5'h1F)
            secs <= secs + 5'h01;
        end else begin
          tenth_reg <= tenth_reg + 4'h1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ### src/tick_gen.v
`timescale 1ns/1ps
`default_nettype none

module tick_gen #(
  parameter TICK_CYCLES = 2500000
) (
  input  wire clk,
  input  wire rst_b,
  output reg  tick
);

  localparam [21:0] LAST = TICK_CYCLES - 1;

  reg [21:0] cnt_reg;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 22'h000000;
      tick    <= 1'b0;
    end else if (cnt_reg >= LAST) begin
      cnt_reg <= 22'h000000;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 22'h000001;
      tick    <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### src/transponder_control.v
`timescale 1ns/1ps
`default_nettype none

`include "transponder_defines.vh"

// Behaviour
// - Quiet-mode ident hold 1-4 opens identity view
// - View shows address, category, flight identifier
// - Identity view exits itself after five seconds
// - Hold 5-19 opens identifier edit, cursor, knob
// - Mode button stores identifier, returns quiet
// - Mode button cycles quiet, all, no-altitude
// - Quiet mode: no replies, no squitter
// - All-replies mode answers A, C, S
// - No-altitude mode drops altitude from C, S
// - Zero address: no Mode S, other modes
// - Non-selective altitude mode: A and C only
// - Identity-only mode: Mode A replies only
// - Active and standby codes, edit, swap
// - Visual-flight code 7000, press activates it
// - Reveal standby while visual-flight code active
// - Three second hold stores visual-flight code
// - Ident press gives 18 s position pulse
// - Drive suppression, yield to other transmitters
// - Ground sense low and enabled: ground mode
// - Power-follow tied high: start, ignore button
// - Every power-up starts in quiet mode
// - Button: on after 0.5 s, off 3 s
module transponder_control #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input  wire         SYS_CLK,
  input  wire         RST_B,
  input  wire         BTN_MODE,
  input  wire         BTN_IDENT,
  input  wire         BTN_VFR,
  input  wire         BTN_SWAP,
  input  wire         BTN_CURSOR,
  input  wire         KNOB_UP,
  input  wire         KNOB_DN,
  input  wire         BTN_POWER,
  input  wire         POWER_FOLLOW,
  input  wire         GROUND_SENSE_B,
  input  wire         GROUND_SENSE_EN,
  input  wire [23:0]  AIRCRAFT_ADDRESS,
  input  wire         ADDRESS_VALID,
  input  wire [7:0]   AIRCRAFT_CATEGORY,
  input  wire         REPLY_ACTIVE,
  input  wire         SUPP_IN,
  output reg          SUPP_OUT,
  output reg          SUPP_OE_B,
  output reg          POWER_ON,
  output reg  [2:0]   REPLY_MODE,
  output reg          MODE_S_OFF,
  output reg          EN_MODE_A,
  output reg          EN_MODE_C,
  output reg          EN_MODE_S,
  output reg          EN_ALTITUDE,
  output reg          EN_SQUITTER,
  output reg          TX_PERMIT,
  output reg          SPI_ENABLE,
  output reg          IDENT_IND,
  output reg  [11:0]  ACTIVE_CODE,
  output reg  [11:0]  STANDBY_CODE,
  output reg  [11:0]  VFR_CODE,
  output reg          VFR_IND,
  output reg          STANDBY_SHOWN,
  output reg          STORE_MARK,
  output reg  [2:0]   CURSOR_POS,
  output reg  [1:0]   SCREEN,
  output reg  [4:0]   HOLD_COUNT,
  output reg  [127:0] DISP_LINE,
  output reg  [63:0]  FLIGHT_IDENTIFIER,
  output reg          GROUND_MODE
);

  // ==========================================================
  // States and constants
  localparam [2:0] QUIET_MODE                  = 3'h0;
  localparam [2:0] ALL_REPLIES_MODE            = 3'h1;
  localparam [2:0] NO_ALTITUDE_MODE            = 3'h2;
  localparam [2:0] NON_SELECTIVE_ALTITUDE_MODE = 3'h3;
  localparam [2:0] IDENTITY_ONLY_MODE          = 3'h4;

  localparam [1:0] SCR_NORMAL   = 2'h0;
  localparam [1:0] SCR_ID_VIEW  = 2'h1;
  localparam [1:0] SCR_FID_EDIT = 2'h2;

  localparam [7:0] ID_SCREEN_TICKS = `ID_SCREEN_TICKS;
  localparam [7:0] SPI_TICKS       = `SPI_TICKS;
  localparam [7:0] VFR_STORE_TICKS = `VFR_STORE_TICKS;
  localparam [7:0] PWR_ON_TICKS    = `PWR_ON_TICKS;
  localparam [7:0] PWR_OFF_TICKS   = `PWR_OFF_TICKS;
  localparam [4:0] ID_VIEW_MIN     = `ID_VIEW_MIN_S;
  localparam [4:0] ID_VIEW_MAX     = `ID_VIEW_MAX_S;
  localparam [4:0] FID_EDIT_MIN    = `FID_EDIT_MIN_S;
  localparam [4:0] FID_EDIT_MAX    = `FID_EDIT_MAX_S;

  // ==========================================================
  // Functions
  function [7:0] hex_char;
    input [3:0] n;
    begin
      hex_char = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    end
  endfunction

  // Character set: blank, 0-9, A-Z, wrapping both ways
  function [7:0] char_step;
    input [7:0] c;
    input       up;
    begin
      if (up) begin
        if (c == `CHAR_BLANK)  char_step = 8'h30;
        else if (c == 8'h39)   char_step = 8'h41;
        else if (c >= 8'h5A)   char_step = `CHAR_BLANK;
        else                   char_step = c + 8'h01;
      end else begin
        if (c == `CHAR_BLANK)  char_step = 8'h5A;
        else if (c == 8'h41)   char_step = 8'h39;
        else if (c <= 8'h30)   char_step = `CHAR_BLANK;
        else                   char_step = c - 8'h01;
      end
    end
  endfunction

  // Octal digit edit; position 0 is the leftmost digit
  function [11:0] digit_step;
    input [11:0] code;
    input [1:0]  pos;
    input        up;
    reg   [11:0] r;
    begin
      r = code;
      case (pos)
        2'h0:    r[11:9] = up ? code[11:9] + 3'h1 : code[11:9] - 3'h1;
        2'h1:    r[8:6]  = up ? code[8:6]  + 3'h1 : code[8:6]  - 3'h1;
        2'h2:    r[5:3]  = up ? code[5:3]  + 3'h1 : code[5:3]  - 3'h1;
        default: r[2:0]  = up ? code[2:0]  + 3'h1 : code[2:0]  - 3'h1;
      endcase
      digit_step = r;
    end
  endfunction

  // ==========================================================
  // Time base and button hold timers
  wire       tick;
  wire       id_held, id_press, id_rel;
  wire       vfr_held, vfr_press, vfr_rel;
  wire       pwr_held, pwr_press, pwr_rel;
  wire [7:0] id_ticks, vfr_ticks, pwr_ticks;
  wire [4:0] id_secs;

  tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk   (SYS_CLK),
    .rst_b (RST_B),
    .tick  (tick)
  );

  hold_timer u_hold_ident (
    .clk         (SYS_CLK),
    .rst_b       (RST_B),
    .btn         (BTN_IDENT),
    .tick        (tick),
    .held        (id_held),
    .press       (id_press),
    .release_evt (id_rel),
    .ticks       (id_ticks),
    .secs        (id_secs)
  );

  hold_timer u_hold_vfr (
    .clk         (SYS_CLK),
    .rst_b       (RST_B),
    .btn         (BTN_VFR),
    .tick        (tick),
    .held        (vfr_held),
    .press       (vfr_press),
    .release_evt (vfr_rel),
    .ticks       (vfr_ticks),
    .secs        ()
  );

  hold_timer u_hold_power (
    .clk         (SYS_CLK),
    .rst_b       (RST_B),
    .btn         (BTN_POWER),
    .tick        (tick),
    .held        (pwr_held),
    .press       (pwr_press),
    .release_evt (pwr_rel),
    .ticks       (pwr_ticks),
    .secs        ()
  );

  // ==========================================================
  // Internal state
  reg        pwr_armed_reg;
  reg        mode_press_reg;
  reg [7:0]  screen_cnt_reg;
  reg [7:0]  spi_cnt_reg;
  reg [63:0] fid_edit_reg;
  reg [2:0]  fid_cur_reg;
  reg [1:0]  sq_cur_reg;

  wire mode_press = BTN_MODE & ~mode_press_reg;
  wire no_mode_s  = ~ADDRESS_VALID | (AIRCRAFT_ADDRESS == 24'h000000);
  wire normal     = (SCREEN == SCR_NORMAL);
  wire knob       = KNOB_UP | KNOB_DN;
  wire vfr_hidden = VFR_IND & ~STANDBY_SHOWN;
  wire [5:0] fid_lsb = {3'h7 - fid_cur_reg, 3'h0};

  // ==========================================================
  // Power control
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      POWER_ON      <= 1'b0;
      pwr_armed_reg <= 1'b0;
    end else if (POWER_FOLLOW) begin
      POWER_ON      <= 1'b1;
      pwr_armed_reg <= 1'b0;
    end else begin
      // One action per press, so the on-hold never runs on into an off
      if (pwr_press)
        pwr_armed_reg <= 1'b1;
      else if (pwr_rel)
        pwr_armed_reg <= 1'b0;
      if (pwr_held && pwr_armed_reg) begin
        if (!POWER_ON && pwr_ticks >= PWR_ON_TICKS) begin
          POWER_ON      <= 1'b1;
          pwr_armed_reg <= 1'b0;
        end else if (POWER_ON && pwr_ticks >= PWR_OFF_TICKS) begin
          POWER_ON      <= 1'b0;
          pwr_armed_reg <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Modes, screens, codes and ident
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode_press_reg    <= 1'b0;
      REPLY_MODE        <= QUIET_MODE;
      SCREEN            <= SCR_NORMAL;
      screen_cnt_reg    <= 8'h00;
      spi_cnt_reg       <= 8'h00;
      ACTIVE_CODE       <= 12'h000;
      STANDBY_CODE      <= 12'h000;
      VFR_CODE          <= `VFR_CODE_RESET;
      VFR_IND           <= 1'b0;
      STANDBY_SHOWN     <= 1'b1;
      STORE_MARK        <= 1'b0;
      FLIGHT_IDENTIFIER <= `FID_RESET;
      fid_edit_reg      <= `FID_RESET;
      fid_cur_reg       <= 3'h0;
      sq_cur_reg        <= 2'h0;
    end else if (!POWER_ON) begin
      // Held off: the next power-up always starts quiet
      mode_press_reg <= BTN_MODE;
      REPLY_MODE     <= QUIET_MODE;
      SCREEN         <= SCR_NORMAL;
      screen_cnt_reg <= 8'h00;
      spi_cnt_reg    <= 8'h00;
      STORE_MARK     <= 1'b0;
    end else begin
      mode_press_reg <= BTN_MODE;

      // Ident interval
      if (id_press && REPLY_MODE != QUIET_MODE)
        spi_cnt_reg <= SPI_TICKS;
      else if (tick && spi_cnt_reg != 8'h00)
        spi_cnt_reg <= spi_cnt_reg - 8'h01;

      case (SCREEN)
        SCR_NORMAL: begin
          if (mode_press) begin
            case (REPLY_MODE)
              QUIET_MODE:       REPLY_MODE <= no_mode_s ? NON_SELECTIVE_ALTITUDE_MODE
                                                        : ALL_REPLIES_MODE;
              ALL_REPLIES_MODE: REPLY_MODE <= NO_ALTITUDE_MODE;
              NON_SELECTIVE_ALTITUDE_MODE: REPLY_MODE <= IDENTITY_ONLY_MODE;
              default:          REPLY_MODE <= QUIET_MODE;
            endcase
          end
          if (id_rel && REPLY_MODE == QUIET_MODE) begin
            if (id_secs >= ID_VIEW_MIN && id_secs <= ID_VIEW_MAX) begin
              SCREEN         <= SCR_ID_VIEW;
              screen_cnt_reg <= ID_SCREEN_TICKS;
            end else if (id_secs >= FID_EDIT_MIN && id_secs <= FID_EDIT_MAX) begin
              SCREEN       <= SCR_FID_EDIT;
              fid_edit_reg <= FLIGHT_IDENTIFIER;
              fid_cur_reg  <= 3'h0;
            end
          end
        end
        SCR_ID_VIEW: begin
          // Screen buttons are ignored; only the timeout or a power-off leaves this screen
          if (tick) begin
            if (screen_cnt_reg <= 8'h01)
              SCREEN <= SCR_NORMAL;
            screen_cnt_reg <= screen_cnt_reg - 8'h01;
          end
        end
        SCR_FID_EDIT: begin
          if (mode_press) begin
            FLIGHT_IDENTIFIER <= fid_edit_reg;
            SCREEN            <= SCR_NORMAL;
            REPLY_MODE        <= QUIET_MODE;
          end else if (BTN_CURSOR) begin
            fid_cur_reg <= fid_cur_reg + 3'h1;
          end else if (knob) begin
            fid_edit_reg[fid_lsb +: 8] <= char_step(fid_edit_reg[fid_lsb +: 8], KNOB_UP);
          end
        end
        default: SCREEN <= SCR_NORMAL;
      endcase

      // Squawk handling on the normal screen
      if (normal) begin
        if (vfr_held && vfr_ticks >= VFR_STORE_TICKS && !STORE_MARK) begin
          VFR_CODE   <= ACTIVE_CODE;
          STORE_MARK <= 1'b1;
        end else if (vfr_rel) begin
          STORE_MARK <= 1'b0;
          if (!STORE_MARK) begin
            if (VFR_IND) begin
              STANDBY_SHOWN <= 1'b1;
            end else begin
              ACTIVE_CODE   <= VFR_CODE;
              STANDBY_CODE  <= ACTIVE_CODE;
              VFR_IND       <= 1'b1;
              STANDBY_SHOWN <= 1'b0;
            end
          end
        end else if (BTN_SWAP) begin
          if (vfr_hidden) begin
            STANDBY_SHOWN <= 1'b1;
          end else begin
            ACTIVE_CODE   <= STANDBY_CODE;
            STANDBY_CODE  <= ACTIVE_CODE;
            VFR_IND       <= 1'b0;
          end
        end else if (knob) begin
          if (vfr_hidden)
            STANDBY_SHOWN <= 1'b1;
          else
            STANDBY_CODE <= digit_step(STANDBY_CODE, sq_cur_reg, KNOB_UP);
        end else if (BTN_CURSOR) begin
          sq_cur_reg <= sq_cur_reg + 2'h1;
        end
      end
    end
  end

  // ==========================================================
  // Reply enables, suppression and displayed state
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      MODE_S_OFF  <= 1'b1;
      EN_MODE_A   <= 1'b0;
      EN_MODE_C   <= 1'b0;
      EN_MODE_S   <= 1'b0;
      EN_ALTITUDE <= 1'b0;
      EN_SQUITTER <= 1'b0;
      TX_PERMIT   <= 1'b0;
      SUPP_OUT    <= 1'b0;
      SUPP_OE_B   <= 1'b1;
      SPI_ENABLE  <= 1'b0;
      IDENT_IND   <= 1'b0;
      GROUND_MODE <= 1'b0;
      CURSOR_POS  <= 3'h0;
      HOLD_COUNT  <= 5'h00;
      DISP_LINE   <= {16{`CHAR_BLANK}};
    end else begin
      MODE_S_OFF  <= no_mode_s;
      EN_MODE_A   <= POWER_ON & (REPLY_MODE != QUIET_MODE);
      EN_MODE_C   <= POWER_ON & ((REPLY_MODE == ALL_REPLIES_MODE) |
                                 (REPLY_MODE == NON_SELECTIVE_ALTITUDE_MODE));
      EN_MODE_S   <= POWER_ON & ~no_mode_s & ((REPLY_MODE == ALL_REPLIES_MODE) |
                                              (REPLY_MODE == NO_ALTITUDE_MODE));
      EN_ALTITUDE <= POWER_ON & ((REPLY_MODE == ALL_REPLIES_MODE) |
                                 (REPLY_MODE == NON_SELECTIVE_ALTITUDE_MODE));
      EN_SQUITTER <= POWER_ON & ~no_mode_s & ((REPLY_MODE == ALL_REPLIES_MODE) |
                                              (REPLY_MODE == NO_ALTITUDE_MODE));
      // Our own drive reads back on the line, so only a foreign drive blocks
      TX_PERMIT   <= POWER_ON & (REPLY_MODE != QUIET_MODE) & ~(SUPP_IN & SUPP_OE_B);
      SUPP_OUT    <= 1'b1;
      SUPP_OE_B   <= ~(REPLY_ACTIVE & TX_PERMIT);
      SPI_ENABLE  <= (spi_cnt_reg != 8'h00);
      IDENT_IND   <= (spi_cnt_reg != 8'h00);
      GROUND_MODE <= GROUND_SENSE_EN & ~GROUND_SENSE_B;
      CURSOR_POS  <= (SCREEN == SCR_FID_EDIT) ? fid_cur_reg : {1'b0, sq_cur_reg};
      HOLD_COUNT  <= (id_held && normal && REPLY_MODE == QUIET_MODE) ? id_secs : 5'h00;
      case (SCREEN)
        SCR_ID_VIEW:  DISP_LINE <= {hex_char(AIRCRAFT_ADDRESS[23:20]),
                                    hex_char(AIRCRAFT_ADDRESS[19:16]),
                                    hex_char(AIRCRAFT_ADDRESS[15:12]),
                                    hex_char(AIRCRAFT_ADDRESS[11:8]),
                                    hex_char(AIRCRAFT_ADDRESS[7:4]),
                                    hex_char(AIRCRAFT_ADDRESS[3:0]),
                                    hex_char(AIRCRAFT_CATEGORY[7:4]),
                                    hex_char(AIRCRAFT_CATEGORY[3:0]),
                                    FLIGHT_IDENTIFIER};
        SCR_FID_EDIT: DISP_LINE <= {{8{`CHAR_BLANK}}, fid_edit_reg};
        default:      DISP_LINE <= {16{`CHAR_BLANK}};
      endcase
    end
  end

endmodule

`default_nettype wire

// ### src/transponder_defines.vh
`ifndef TRANSPONDER_DEFINES_VH
`define TRANSPONDER_DEFINES_VH

// ==========================================================
// Time base
`define CLK_PERIOD_NS     40
`define TICK_PERIOD_NS    100000000
`define TICK_CYCLES       (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

// ==========================================================
// Timing in 0.1 s ticks
`define ID_SCREEN_TICKS   50
`define SPI_TICKS         180
`define VFR_STORE_TICKS   30
`define PWR_ON_TICKS      5
`define PWR_OFF_TICKS     30
`define TICKS_PER_S       10

// ==========================================================
// Ident hold counter windows, in seconds
`define ID_VIEW_MIN_S     1
`define ID_VIEW_MAX_S     4
`define FID_EDIT_MIN_S    5
`define FID_EDIT_MAX_S    19

// ==========================================================
// Reset values
`define VFR_CODE_RESET    12'hE00
`define FID_RESET         64'h2020202020202020
`define CHAR_BLANK        8'h20

`endif

// ### src/unused_none.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### testbench/suppression_partner.sv
`timescale 1ns/1ps
`default_nettype none
module suppression_partner #(
  parameter int REPLY_LEN = 6
) (
  input  wire logic clk,
  input  wire logic interrogate,
  input  wire logic other_tx,
  input  wire logic tx_permit,
  input  wire logic supp_out,
  input  wire logic supp_oe_b,
  output wire logic reply_active,
  output wire logic supp_line
);
  int remain = 0;
  // Wired-or line: any unit driving it wins
  assign supp_line = other_tx | (~supp_oe_b & supp_out);
  assign reply_active = (remain != 0);
  always @(posedge clk) begin
    if (interrogate && tx_permit && remain == 0) begin
      remain <= REPLY_LEN;
    end else if (remain != 0) begin
      remain <= remain - 1;
    end
  end
endmodule
`default_nettype wire

// ### testbench/transponder_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
module transponder_checker (
  input wire logic        SYS_CLK,
  input wire logic        RST_B,
  input wire logic        BTN_IDENT,
  input wire logic        POWER_FOLLOW,
  input wire logic        GROUND_SENSE_B,
  input wire logic        GROUND_SENSE_EN,
  input wire logic [23:0] AIRCRAFT_ADDRESS,
  input wire logic        ADDRESS_VALID,
  input wire logic        REPLY_ACTIVE,
  input wire logic        SUPP_IN,
  input wire logic        SUPP_OE_B,
  input wire logic        POWER_ON,
  input wire logic [2:0]  REPLY_MODE,
  input wire logic        EN_MODE_A,
  input wire logic        EN_MODE_C,
  input wire logic        EN_MODE_S,
  input wire logic        EN_ALTITUDE,
  input wire logic        EN_SQUITTER,
  input wire logic        TX_PERMIT,
  input wire logic        SPI_ENABLE,
  input wire logic        IDENT_IND,
  input wire logic        GROUND_MODE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  // ==========================================
  // Ident: press outside quiet, then pulse flag
  sequence ident_press;
    $rose(BTN_IDENT) && POWER_ON && (REPLY_MODE != 3'h0);
  endsequence
  sequence ident_shown;
    ##[1:3] (SPI_ENABLE && IDENT_IND);
  endsequence
  AST_QUIET_SILENT: assert property ((REPLY_MODE == 3'h0) |=>
    !(EN_MODE_A || EN_MODE_C || EN_MODE_S || EN_SQUITTER)) else $error("quiet mode replies");
  AST_ALL_REPLIES: assert property ((REPLY_MODE == 3'h1) && POWER_ON && ADDRESS_VALID
    && (AIRCRAFT_ADDRESS != 24'h0) |=> EN_MODE_A && EN_MODE_C && EN_MODE_S && EN_ALTITUDE)
    else $error("all-replies enables wrong");
  AST_NO_ALTITUDE: assert property ((REPLY_MODE == 3'h2) && POWER_ON |=>
    EN_MODE_A && !EN_MODE_C && !EN_ALTITUDE) else $error("altitude not dropped");
  AST_NO_MODE_S: assert property ((!ADDRESS_VALID || AIRCRAFT_ADDRESS == 24'h0) |=>
    !EN_MODE_S && !EN_SQUITTER) else $error("mode S without address");
  AST_NON_SELECTIVE: assert property ((REPLY_MODE == 3'h3) && POWER_ON |=>
    EN_MODE_A && EN_MODE_C && !EN_MODE_S && !EN_SQUITTER) else $error("A+C enables wrong");
  AST_IDENTITY_ONLY: assert property ((REPLY_MODE == 3'h4) && POWER_ON |=>
    EN_MODE_A && !EN_MODE_C && !EN_MODE_S && !EN_ALTITUDE) else $error("A-only enables wrong");
  AST_IDENT_PULSE: assert property (ident_press |-> ident_shown)
    else $error("ident pulse missing");
  AST_SUPP_DRIVE: assert property (REPLY_ACTIVE && TX_PERMIT |=> !SUPP_OE_B)
    else $error("suppression not driven");
  AST_SUPP_YIELD: assert property (SUPP_IN && SUPP_OE_B |=> !TX_PERMIT)
    else $error("sent while suppressed");
  AST_GROUND_ON: assert property (GROUND_SENSE_EN && !GROUND_SENSE_B |=> GROUND_MODE)
    else $error("ground mode missed");
  AST_AIRBORNE_OPEN: assert property (GROUND_SENSE_B |=> !GROUND_MODE)
    else $error("open input not airborne");
  AST_FOLLOW_ON: assert property (POWER_FOLLOW |=> POWER_ON)
    else $error("power-follow ignored");
  AST_POWER_UP_QUIET: assert property ($rose(POWER_ON) |-> REPLY_MODE == 3'h0)
    else $error("power-up not quiet");
endmodule
bind transponder_control transponder_checker chk (.*);
`default_nettype wire

// ### testbench/transponder_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module transponder_control_bench;
  localparam int TC = 4;
  logic         SYS_CLK, RST_B, POWER_FOLLOW, GROUND_SENSE_B, GROUND_SENSE_EN;
  logic         ADDRESS_VALID, interrogate, other_tx;
  logic [7:0]   btn;
  logic [23:0]  AIRCRAFT_ADDRESS;
  wire          REPLY_ACTIVE, SUPP_LINE, SUPP_OUT, SUPP_OE_B, POWER_ON, TX_PERMIT;
  wire          SPI_ENABLE, IDENT_IND, VFR_IND, STANDBY_SHOWN, STORE_MARK, GROUND_MODE;
  wire [2:0]    REPLY_MODE;
  wire [4:0]    en;
  wire [11:0]   ACTIVE_CODE, STANDBY_CODE, VFR_CODE;
  wire [1:0]    SCREEN;
  wire [127:0]  DISP_LINE;
  wire [63:0]   FLIGHT_IDENTIFIER;
  int           failures = 0;
  int           samples_checked = 0;
  // ==========================================
  // Design and far side
  transponder_control #(.TICK_CYCLES(TC)) dut (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
    .BTN_MODE(btn[0]), .BTN_IDENT(btn[1]), .BTN_VFR(btn[2]), .BTN_POWER(btn[3]),
    .BTN_SWAP(btn[4]), .BTN_CURSOR(btn[5]), .KNOB_UP(btn[6]), .KNOB_DN(btn[7]),
    .POWER_FOLLOW(POWER_FOLLOW), .GROUND_SENSE_B(GROUND_SENSE_B),
    .GROUND_SENSE_EN(GROUND_SENSE_EN), .AIRCRAFT_ADDRESS(AIRCRAFT_ADDRESS),
    .ADDRESS_VALID(ADDRESS_VALID), .AIRCRAFT_CATEGORY(8'h1C), .REPLY_ACTIVE(REPLY_ACTIVE),
    .SUPP_IN(SUPP_LINE), .SUPP_OUT(SUPP_OUT), .SUPP_OE_B(SUPP_OE_B), .POWER_ON(POWER_ON),
    .REPLY_MODE(REPLY_MODE), .MODE_S_OFF(), .EN_MODE_A(en[4]), .EN_MODE_C(en[3]),
    .EN_MODE_S(en[2]), .EN_ALTITUDE(en[1]), .EN_SQUITTER(en[0]), .TX_PERMIT(TX_PERMIT),
    .SPI_ENABLE(SPI_ENABLE), .IDENT_IND(IDENT_IND), .ACTIVE_CODE(ACTIVE_CODE),
    .STANDBY_CODE(STANDBY_CODE), .VFR_CODE(VFR_CODE), .VFR_IND(VFR_IND),
    .STANDBY_SHOWN(STANDBY_SHOWN), .STORE_MARK(STORE_MARK), .CURSOR_POS(), .SCREEN(SCREEN),
    .HOLD_COUNT(), .DISP_LINE(DISP_LINE), .FLIGHT_IDENTIFIER(FLIGHT_IDENTIFIER),
    .GROUND_MODE(GROUND_MODE));
  suppression_partner #(.REPLY_LEN(6)) far (.clk(SYS_CLK), .interrogate(interrogate),
    .other_tx(other_tx), .tx_permit(TX_PERMIT), .supp_out(SUPP_OUT), .supp_oe_b(SUPP_OE_B),
    .reply_active(REPLY_ACTIVE), .supp_line(SUPP_LINE));
  // ==========================================
  // Access tasks
  task step(input int n);
    repeat (n) @(negedge SYS_CLK);
  endtask
  task hold(input int b, input int ticks);
    btn[b] = 1'b1;
    step(ticks * TC);
    btn[b] = 1'b0;
    step(4);
  endtask
  task tap(input int b);
    btn[b] = 1'b1;
    step(1);
    btn[b] = 1'b0;
    step(4);
  endtask
  task chk_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task chk_vec(input string what, input logic [127:0] exp, input logic [127:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================
  // Clock, watchdog, tests
  initial begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    step(8000);
    failures++;
    give_verdict();
  end
  initial begin
    {RST_B, POWER_FOLLOW, GROUND_SENSE_EN, interrogate, other_tx, btn} = '0;
    GROUND_SENSE_B = 1'b1;
    ADDRESS_VALID = 1'b1;
    AIRCRAFT_ADDRESS = 24'hABC123;
    step(6);
    RST_B = 1'b1;
    step(2);
    chk_vec("vfr_code", 12'hE00, VFR_CODE);
    chk_vec("reply_mode", 3'h0, REPLY_MODE);
    hold(3, 3);
    chk_bit("power_on", 1'b0, POWER_ON);
    hold(3, 7);
    chk_bit("power_on", 1'b1, POWER_ON);
    $display("test power-up done");
    tap(0);
    chk_vec("enables", 5'h1F, en);
    tap(0);
    chk_vec("enables", 5'h15, en);
    tap(0);
    chk_vec("enables", 5'h00, en);
    ADDRESS_VALID = 1'b0;
    tap(0);
    chk_vec("mode", 3'h3, REPLY_MODE);
    chk_vec("enables", 5'h1A, en);
    tap(0);
    chk_vec("enables", 5'h10, en);
    tap(0);
    chk_vec("mode", 3'h0, REPLY_MODE);
    ADDRESS_VALID = 1'b1;
    $display("test modes done");
    tap(0);
    other_tx = 1'b1;
    step(3);
    chk_bit("tx_permit", 1'b0, TX_PERMIT);
    interrogate = 1'b1;
    step(1);
    {interrogate, other_tx} = 2'b00;
    step(3);
    chk_bit("supp_oe_b", 1'b1, SUPP_OE_B);
    interrogate = 1'b1;
    step(1);
    interrogate = 1'b0;
    step(3);
    chk_bit("supp_oe_b", 1'b0, SUPP_OE_B);
    chk_bit("tx_permit", 1'b1, TX_PERMIT);
    step(8);
    chk_bit("supp_oe_b", 1'b1, SUPP_OE_B);
    {GROUND_SENSE_EN, GROUND_SENSE_B} = 2'b10;
    step(3);
    chk_bit("ground", 1'b1, GROUND_MODE);
    GROUND_SENSE_B = 1'b1;
    step(3);
    chk_bit("ground", 1'b0, GROUND_MODE);
    $display("test suppression done");
    tap(1);
    chk_bit("ident", 1'b1, SPI_ENABLE & IDENT_IND);
    step(100 * TC);
    tap(1);
    step(100 * TC);
    chk_bit("ident", 1'b1, SPI_ENABLE);
    step(90 * TC);
    chk_bit("ident", 1'b0, SPI_ENABLE | IDENT_IND);
    $display("test ident done");
    tap(6);
    tap(5);
    tap(7);
    chk_vec("standby", 12'h3C0, STANDBY_CODE);
    tap(4);
    chk_vec("active", 12'h3C0, ACTIVE_CODE);
    tap(2);
    chk_vec("codes", {12'hE00, 12'h3C0, 2'b10}, {ACTIVE_CODE, STANDBY_CODE, VFR_IND, STANDBY_SHOWN});
    tap(2);
    chk_vec("vfr_shown", {12'hE00, 2'b11}, {ACTIVE_CODE, VFR_IND, STANDBY_SHOWN});
    tap(4);
    chk_vec("swap", {12'h3C0, 12'hE00, 1'b0}, {ACTIVE_CODE, STANDBY_CODE, VFR_IND});
    btn[2] = 1'b1;
    step(25 * TC);
    chk_bit("store_mark", 1'b0, STORE_MARK);
    step(8 * TC);
    chk_bit("store_mark", 1'b1, STORE_MARK);
    chk_vec("vfr_code", 12'h3C0, VFR_CODE);
    btn[2] = 1'b0;
    step(4);
    chk_vec("after store", {12'h3C0, 2'b00}, {ACTIVE_CODE, VFR_IND, STORE_MARK});
    $display("test squawk done");
    tap(0);
    tap(0);
    hold(1, 25);
    chk_vec("screen", 2'h1, SCREEN);
    chk_vec("view", "ABC1231C        ", DISP_LINE);
    step(45 * TC);
    chk_vec("screen", 2'h1, SCREEN);
    step(12 * TC);
    chk_vec("screen", 2'h0, SCREEN);
    hold(1, 65);
    chk_vec("screen", 2'h2, SCREEN);
    tap(6);
    tap(5);
    tap(6);
    tap(6);
    chk_vec("edit", "        01      ", DISP_LINE);
    tap(0);
    chk_vec("fid", {2'h0, "01      "}, {SCREEN, FLIGHT_IDENTIFIER});
    $display("test identifier done");
    tap(0);
    hold(3, 35);
    chk_vec("off", 4'h0, {POWER_ON, REPLY_MODE});
    POWER_FOLLOW = 1'b1;
    step(3);
    chk_bit("power_on", 1'b1, POWER_ON);
    hold(3, 35);
    chk_vec("follow", 4'h8, {POWER_ON, REPLY_MODE});
    $display("test power-follow done");
    give_verdict();
  end
endmodule
`default_nettype wire
